// ==== sts_regs.vh ====
`ifndef STS_REGS_VH
`define STS_REGS_VH
// APB register byte offsets
`define STS_CTRL_ADDR 12'h000
`define STS_COUNT_ADDR 12'h004
`define STS_LIST_ADDR 12'h008
`define STS_TIMER_ADDR 12'h00C
`define STS_DELAY_ADDR 12'h010
`define STS_RATIO_ADDR 12'h014
`define STS_STATUS_ADDR 12'h018
`define STS_AUTO_ADDR 12'h01C
// Control register fields
`define STS_CTRL_RUN 0
`define STS_CTRL_SCAN 1
`define STS_CTRL_SRC_LO 2
`define STS_CTRL_SRC_HI 3
`define STS_CTRL_AUTO 4
`define STS_CTRL_RATIO 5
`define STS_CTRL_FILT 6
`define STS_CTRL_STOP 7
`define STS_CTRL_MANTRIG 8
// Control source encodings
`define STS_SRC_IMM 2'h0
`define STS_SRC_TMR 2'h1
`define STS_SRC_EXT 2'h2
// Time unit: delays and timer count in milliseconds
`define STS_MS_NS 1000000
`define STS_CLK_NS 10
`define STS_MS_CYC (`STS_MS_NS / `STS_CLK_NS)
// Range limits and ratio default in milliseconds
`define STS_TIMER_MAX_MS 40'h003B9AC9FF
`define STS_DELAY_MAX_MS 40'h00159A653F
`define STS_RATIO_DEF_MS 40'h00000001F4
// Reset values and output trigger pulse length in cycles
`define STS_COUNT_RST 20'h00000
`define STS_LIST_RST 8'h01
`define STS_PULSE_CYC 4'h8
`endif

// ==== sts_sequencer.v ====
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "sts_regs.vh"
// Function
// - Enable leaves idle, then waits at source
// - Run end returns idle; scan mode leaves channel one selected
// - Immediate, timer, external sources; stall until event
// - Step mode: one channel per event
// - Scan mode: whole list per event
// - Immediate source satisfies event at once
// - Timer source: first pass skips timer wait
// - Later timer passes wait max(timer, delay)
// - Timer 0..999999.999 s, resets at run start
// - Timer paces channels (step) or scans (scan)
// - External start needs pulse or manual trigger
// - External trigger advances channel or whole scan
// - Auto delay is one software-written value
// - Manual delay up to 99h99m99.999s allowed
// - Ratio delay after main delay, default 0.5s
// - Request measurement, with filter when enabled
// - Step count may wrap; restart resumes next channel
// - Step mode uses one trigger counter
// - Scans equal count over list length, rounded up
// - Scan uses sample and trigger counters
// - Infinite count repeats until stop request
// - Output trigger per channel or per scan
module sts_sequencer (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // External trigger in and out
  input wire ext_manual_trigger_request_in,
  output reg manual_trigger_request_out,
  // Measurement engine handshake
  input wire meas_done,
  output reg meas_req,
  output reg filter_en,
  output reg [7:0] chan_sel
);

  // Sequencer states
  // Flow of one pass: idle, then wait at the control source, then the main
  // delay, then the optional ratio delay, then the measurement handshake,
  // then the bookkeeping state that advances the channel and the counters.
  // Idle is only left on a rising run bit, so a run bit that software
  // leaves set after a finished run does not start a second run by itself.
  // Within a scan the bookkeeping state loops straight back to the main
  // delay, so the timer never stretches the gap between channels.
  // Between scans or steps it returns to the wait state, where the timer
  // interval can take over from the delay once the first pass is done.
  // Codes are plain binary; the status register shows them to software,
  // so keep them stable if a state is ever added.
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_DLY = 3'h2;
  localparam ST_RDLY = 3'h3;
  localparam ST_MEAS = 3'h4;
  localparam ST_NEXT = 3'h5;

  // Software registers
  // All times are held in whole milliseconds. A value of zero means no
  // wait at all, which keeps short bench runs practical. Values beyond the
  // documented range are clamped on write rather than refused, except the auto
  // delay, which is stored as written; a read back shows what the hardware will use.
  reg [8:0] ctrl_q; // run, scan, source, auto, ratio, filter bits
  reg [19:0] count_q; // Reading count, zero means infinite
  reg [7:0] list_q; // Scan list length, at least one
  reg [39:0] timer_ms_q; // Timer interval in ms
  reg [39:0] delay_ms_q; // Manual delay in ms
  reg [39:0] ratio_ms_q; // Ratio/average delay in ms
  reg [39:0] auto_ms_q; // Auto delay in ms, written by software
  // Sequencer state
  reg [2:0] state_q;
  reg first_q; // First pass of a run: timer bypass
  reg [19:0] manual_trigger_request_cnt_q; // Trigger counter
  reg [7:0] samp_cnt_q; // Sample counter (scan mode)
  reg [39:0] wait_ms_q; // Remaining ms of current delay
  reg [16:0] tick_q; // Cycles within the current ms
  reg [3:0] pulse_q; // Output trigger stretch
  reg man_q; // Pending manual trigger
  reg run_d1_q; // Run bit seen last cycle
  // External input synchroniser
  reg [2:0] ext_sync_q;
  reg ext_seen_q;
  wire ext_evt;
  wire wr_en;
  wire inf_cnt;
  wire [1:0] src;

  assign wr_en = psel & penable & pwrite & pready;
  assign inf_cnt = (count_q == 20'h00000); // infinite_count
  assign src = ctrl_q[`STS_CTRL_SRC_HI:`STS_CTRL_SRC_LO];
  // Edge seen when second and third stages agree high after a low
  assign ext_evt = ext_sync_q[1] & ext_sync_q[2] & ~ext_seen_q;

  // Larger of two millisecond values
  function [39:0] max40;
    input [39:0] a;
    input [39:0] b;
    begin
      max40 = (a > b) ? a : b;
    end
  endfunction

  // Clamp a value to a limit
  function [39:0] clamp40;
    input [39:0] v;
    input [39:0] lim;
    begin
      clamp40 = (v > lim) ? lim : v;
    end
  endfunction

  // Scans = ceil(count / list), by repeated subtraction is too slow, so divide
  function [19:0] scans;
    input [19:0] cnt;
    input [7:0] len;
    reg [20:0] num;
    begin
      num = {1'b0, cnt} + {13'h0000, len} - 21'h000001;
      scans = num[19:0] / {12'h000, len};
    end
  endfunction

  // Three-stage synchroniser; only stages two and three are compared
  // The first stage may go metastable, so nothing but stage two reads it.
  // The seen flag follows the settled level only when stages two and three
  // agree, which filters a single-cycle glitch on the pin.
  // Limitation: pulses shorter than about two clocks may be missed, and
  // edges closer than four clocks apart may merge into one event.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_q <= 3'h0;
      ext_seen_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_manual_trigger_request_in};
      if (ext_sync_q[1] == ext_sync_q[2]) begin
        ext_seen_q <= ext_sync_q[2];
      end
    end
  end

  // APB slave: one wait state, pready registered one cycle into access
  // The access phase therefore always lasts two cycles. Registering pready
  // and the read data costs that one wait state but keeps every output of
  // the block straight from a flip-flop. The read word is captured in the
  // first access cycle and stands while pready is high, so a master that
  // samples on the pready edge always gets a settled value.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        prdata <= 32'h00000000;
        case (paddr)
          `STS_CTRL_ADDR: prdata <= {23'h000000, ctrl_q};
          `STS_COUNT_ADDR: prdata <= {12'h000, count_q};
          `STS_LIST_ADDR: prdata <= {24'h000000, list_q};
          `STS_TIMER_ADDR: prdata <= timer_ms_q[31:0];
          `STS_DELAY_ADDR: prdata <= delay_ms_q[31:0];
          `STS_RATIO_ADDR: prdata <= ratio_ms_q[31:0];
          `STS_AUTO_ADDR: prdata <= auto_ms_q[31:0];
          `STS_STATUS_ADDR: prdata <= {first_q, manual_trigger_request_cnt_q, chan_sel, state_q};
          default: pslverr <= 1'b1; // Unmapped address
        endcase
      end
    end
  end

  // Register writes; stop and manual trigger are self-clearing strobes
  // Hardware clears the run bit when a finite run ends, in the same cycle
  // as the sequencer drops to idle. A software write in that cycle wins,
  // because it comes later in this process; software that rewrites the run
  // bit while a run finishes must expect the run bit to stay set.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 9'h000;
      count_q <= `STS_COUNT_RST;
      list_q <= `STS_LIST_RST;
      timer_ms_q <= 40'h0000000000;
      delay_ms_q <= 40'h0000000000;
      ratio_ms_q <= `STS_RATIO_DEF_MS;
      auto_ms_q <= 40'h0000000001;
      man_q <= 1'b0;
    end else begin
      // Pending manual trigger is consumed by the wait state
      if (state_q == ST_WAIT && src == `STS_SRC_EXT) begin
        man_q <= 1'b0;
      end
      // A run finishing drops the run bit unless infinite
      if (state_q == ST_NEXT && manual_trigger_request_cnt_q == 20'h00001 && !inf_cnt &&
          ((ctrl_q[`STS_CTRL_SCAN] && samp_cnt_q == 8'h01) ||
           !ctrl_q[`STS_CTRL_SCAN])) begin
        ctrl_q[`STS_CTRL_RUN] <= 1'b0;
      end
      ctrl_q[`STS_CTRL_STOP] <= 1'b0;
      ctrl_q[`STS_CTRL_MANTRIG] <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `STS_CTRL_ADDR: begin
            ctrl_q <= pwdata[8:0];
            if (pwdata[`STS_CTRL_STOP]) begin
              ctrl_q[`STS_CTRL_RUN] <= 1'b0;
            end
            if (pwdata[`STS_CTRL_MANTRIG]) begin
              man_q <= 1'b1; // Set wins over clear
            end
          end
          `STS_COUNT_ADDR: count_q <= pwdata[19:0];
          `STS_LIST_ADDR: list_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
          `STS_TIMER_ADDR: timer_ms_q <= clamp40({8'h00, pwdata}, `STS_TIMER_MAX_MS);
          `STS_DELAY_ADDR: delay_ms_q <= clamp40({8'h00, pwdata}, `STS_DELAY_MAX_MS);
          `STS_RATIO_ADDR: ratio_ms_q <= clamp40({8'h00, pwdata}, `STS_TIMER_MAX_MS);
          `STS_AUTO_ADDR: auto_ms_q <= {8'h00, pwdata};
          default: ;
        endcase
      end
    end
  end

  // Sequencer: control source, delays, measure, count, output trigger
  // The output trigger is stretched to a fixed number of cycles so that a
  // slow partner instrument can see it. A new measurement is held back
  // until the previous pulse has ended, so two pulses never merge into one
  // long high level on the line; the price is a few cycles of extra delay
  // per channel in step mode, or per scan in scan mode, when the delays are set to zero.
  // Delays count in whole milliseconds, each made of a fixed number of
  // clock cycles; a zero delay leaves its state after a single cycle.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      first_q <= 1'b1;
      manual_trigger_request_cnt_q <= 20'h00000;
      samp_cnt_q <= 8'h00;
      wait_ms_q <= 40'h0000000000;
      tick_q <= 17'h00000;
      pulse_q <= 4'h0;
      run_d1_q <= 1'b0;
      meas_req <= 1'b0;
      filter_en <= 1'b0;
      manual_trigger_request_out <= 1'b0;
      chan_sel <= 8'h00;
    end else begin
      run_d1_q <= ctrl_q[`STS_CTRL_RUN];
      manual_trigger_request_out <= (pulse_q != 4'h0);
      if (pulse_q != 4'h0) begin
        pulse_q <= pulse_q - 4'h1;
      end
      case (state_q)
        ST_IDLE: begin
          meas_req <= 1'b0;
          // Rising run bit loads counters and drops to the source
          if (ctrl_q[`STS_CTRL_RUN] && !run_d1_q) begin
            first_q <= 1'b1; // Timer back to initial state
            samp_cnt_q <= list_q;
            if (ctrl_q[`STS_CTRL_SCAN]) begin
              manual_trigger_request_cnt_q <= scans(count_q, list_q);
              chan_sel <= 8'h00;
            end else begin
              manual_trigger_request_cnt_q <= count_q;
            end
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Delay choice: timer source after first pass takes the longer of timer and delay
          wait_ms_q <= ctrl_q[`STS_CTRL_AUTO] ? auto_ms_q : delay_ms_q;
          if (src == `STS_SRC_TMR && !first_q) begin
            wait_ms_q <= max40(timer_ms_q,
              ctrl_q[`STS_CTRL_AUTO] ? auto_ms_q : delay_ms_q);
          end
          tick_q <= 17'h00000;
          if (!ctrl_q[`STS_CTRL_RUN]) begin
            state_q <= ST_IDLE;
          end else if (src == `STS_SRC_EXT) begin
            if (ext_evt || man_q) begin
              state_q <= ST_DLY;
            end
          end else begin
            state_q <= ST_DLY; // Immediate and timer satisfied
          end
        end
        ST_DLY: begin
          // Count down whole milliseconds
          if (wait_ms_q == 40'h0000000000) begin
            wait_ms_q <= ratio_ms_q;
            state_q <= ctrl_q[`STS_CTRL_RATIO] ? ST_RDLY : ST_MEAS;
          end else if (tick_q == `STS_MS_CYC - 1) begin
            tick_q <= 17'h00000;
            wait_ms_q <= wait_ms_q - 40'h0000000001;
          end else begin
            tick_q <= tick_q + 17'h00001;
          end
        end
        ST_RDLY: begin
          if (wait_ms_q == 40'h0000000000) begin
            state_q <= ST_MEAS;
          end else if (tick_q == `STS_MS_CYC - 1) begin
            tick_q <= 17'h00000;
            wait_ms_q <= wait_ms_q - 40'h0000000001;
          end else begin
            tick_q <= tick_q + 17'h00001;
          end
        end
        ST_MEAS: begin
          if (pulse_q != 4'h0) begin
            // Previous output pulse still running: hold the request back
            meas_req <= 1'b0;
          end else begin
            // Request stands until the engine answers
            meas_req <= 1'b1;
            filter_en <= ctrl_q[`STS_CTRL_FILT];
            if (meas_req && meas_done) begin
              meas_req <= 1'b0;
              state_q <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          // Advance channel, wrapping through the list
          chan_sel <= (chan_sel + 8'h01 >= list_q) ? 8'h00 : chan_sel + 8'h01;
          tick_q <= 17'h00000;
          if (!ctrl_q[`STS_CTRL_RUN]) begin
            state_q <= ST_IDLE;
          end else if (ctrl_q[`STS_CTRL_SCAN] && samp_cnt_q != 8'h01) begin
            // Within a scan: no timer, only the delay
            samp_cnt_q <= samp_cnt_q - 8'h01;
            wait_ms_q <= ctrl_q[`STS_CTRL_AUTO] ? auto_ms_q : delay_ms_q;
            state_q <= ST_DLY;
          end else begin
            pulse_q <= `STS_PULSE_CYC;
            samp_cnt_q <= list_q;
            first_q <= 1'b0; // Timer paces from here on
            if (!inf_cnt && manual_trigger_request_cnt_q == 20'h00001) begin
              manual_trigger_request_cnt_q <= 20'h00000;
              if (ctrl_q[`STS_CTRL_SCAN]) begin
                chan_sel <= 8'h00; // First channel left selected
              end
              state_q <= ST_IDLE;
            end else begin
              if (!inf_cnt) begin
                manual_trigger_request_cnt_q <= manual_trigger_request_cnt_q - 20'h00001;
              end
              state_q <= ST_WAIT;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

// ==== sts_manual_trigger_request_partner.sv ====
`timescale 1ns/10ps
module sts_manual_trigger_request_partner (
  // Clock
  input wire core_clk,
  // Trigger line pair
  input wire manual_trigger_request_out,
  output reg ext_manual_trigger_request_in = 1'b0,
  // Measurement handshake
  input wire meas_req,
  output reg meas_done = 1'b0
);
  reg [1:0] wait_q = 2'h0; // Cycles spent on the current request
  integer heard = 0; // Output trigger pulses received

  // Engine answers a few cycles late, never at once
  always @(posedge core_clk) begin
    meas_done <= meas_req && !meas_done && wait_q == 2'h2;
    wait_q <= (meas_req && !meas_done) ? wait_q + 2'h1 : 2'h0;
  end

  // Count trigger pulses from the device
  always @(posedge manual_trigger_request_out) begin
    heard = heard + 1;
  end

  // Four-cycle pulse, then a quiet gap so edges stay apart
  task fire;
    begin
      @(posedge core_clk);
      ext_manual_trigger_request_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_manual_trigger_request_in <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule

// ==== sts_seq_sva.sv ====
`timescale 1ns/10ps
module sts_seq_sva (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // APB answer
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Trigger and measure
  input wire manual_trigger_request_out,
  input wire meas_req,
  input wire meas_done,
  input wire filter_en,
  input wire [7:0] chan_sel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Pulse stands eight cycles, then drops
  sequence manual_trigger_request_hold_s;
    manual_trigger_request_out [*8] ##1 !manual_trigger_request_out;
  endsequence
  // Access phase still waiting
  sequence ap_wait_s;
    psel && penable && !pready;
  endsequence
  // Measurement already under way
  sequence meas_on_s;
    meas_req && $past(meas_req);
  endsequence

  ap_wait_a: assert property (ap_wait_s |=> pready) else $error("pready late");
  ap_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  ap_err_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  manual_trigger_request_len_a: assert property ($rose(manual_trigger_request_out) |-> manual_trigger_request_hold_s)
    else $error("trigger pulse width");
  meas_hold_a: assert property (meas_req && !meas_done |=> meas_req)
    else $error("request dropped early");
  meas_end_a: assert property (meas_req && meas_done |=> !meas_req)
    else $error("request held after done");
  chan_hold_a: assert property (meas_on_s |-> $stable(chan_sel))
    else $error("channel moved in measure");
  filt_hold_a: assert property (meas_on_s |-> $stable(filter_en))
    else $error("filter moved in measure");
endmodule

bind sts_sequencer sts_seq_sva u_sva (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .manual_trigger_request_out(manual_trigger_request_out),
  .meas_req(meas_req),
  .meas_done(meas_done),
  .filter_en(filter_en),
  .chan_sel(chan_sel)
);

// ==== tb.sv ====
`timescale 1ns/10ps
`include "sts_regs.vh"
module tb;
  // Clock, reset and APB drive
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  wire [31:0] prdata;
  wire pready, pslverr, ext_manual_trigger_request_in, manual_trigger_request_out, meas_done, meas_req, filter_en;
  wire [7:0] chan_sel;
  // Scoreboard
  integer fails = 0, checks_done = 0, nmeas = 0, ntrig = 0;
  reg [31:0] rd;
  reg er;
  reg manual_trigger_request_d = 1'b0;
  reg saw_filt = 1'b0;
  reg [7:0] last_chan;

  sts_sequencer uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_manual_trigger_request_in(ext_manual_trigger_request_in), .manual_trigger_request_out(manual_trigger_request_out),
    .meas_done(meas_done), .meas_req(meas_req), .filter_en(filter_en), .chan_sel(chan_sel));
  sts_manual_trigger_request_partner u_far (.core_clk(core_clk), .manual_trigger_request_out(manual_trigger_request_out),
    .ext_manual_trigger_request_in(ext_manual_trigger_request_in), .meas_req(meas_req), .meas_done(meas_done));

  // 100 MHz clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // Count finished measurements and trigger edges
  always @(posedge core_clk) begin
    manual_trigger_request_d <= manual_trigger_request_out;
    if (manual_trigger_request_out === 1'b1 && manual_trigger_request_d === 1'b0) ntrig = ntrig + 1;
    if (meas_req === 1'b1 && meas_done === 1'b1) begin
      nmeas = nmeas + 1;
      last_chan = chan_sel;
      saw_filt = saw_filt | filter_en;
    end
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One transfer; no latency assumed, pready decides
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Poll until hardware clears the run bit
  task wait_end;
    begin
      rd = 32'h1;
      while (rd[0] !== 1'b0) apb(1'b0, `STS_CTRL_ADDR, 0);
      repeat (12) @(posedge core_clk);
    end
  endtask

  // Program counts and start; finite non-external runs are awaited
  task run(input [31:0] ctrl, input [31:0] cnt, input [31:0] len);
    begin
      apb(1'b1, `STS_COUNT_ADDR, cnt);
      apb(1'b1, `STS_LIST_ADDR, len);
      nmeas = 0;
      ntrig = 0;
      saw_filt = 1'b0;
      apb(1'b1, `STS_CTRL_ADDR, ctrl);
      if (ctrl[3:2] != `STS_SRC_EXT && cnt != 0) wait_end;
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d errors %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge core_clk);
    fails = fails + 1;
    end_sim;
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, `STS_RATIO_ADDR, 0);
    chk(rd, 32'h000001F4);
    apb(1'b0, `STS_LIST_ADDR, 0);
    chk(rd, 32'h00000001);
    apb(1'b0, `STS_COUNT_ADDR, 0);
    chk(rd, 32'h00000000);
    // Unmapped place: error flag, zero data
    apb(1'b0, 12'h020, 0);
    chk({rd[30:0], er}, 32'h00000001);
    apb(1'b1, `STS_TIMER_ADDR, 32'h000003E7);
    apb(1'b0, `STS_TIMER_ADDR, 0);
    chk(rd, 32'h000003E7);
    // Zero waits keep the run short
    apb(1'b1, `STS_TIMER_ADDR, 0);
    apb(1'b1, `STS_DELAY_ADDR, 0);
    // Step, immediate: count four wraps a list of three
    run(32'h001, 4, 3);
    chk(nmeas, 4);
    chk(ntrig, 4);
    chk(last_chan, 0);
    // Scan with filter: four readings over three channels is two scans
    run(32'h043, 4, 3);
    chk(nmeas, 6);
    chk(ntrig, 2);
    chk(saw_filt, 1);
    chk(chan_sel, 0);
    // Timer source, zero interval, first pass bypassed
    run(32'h007, 4, 2);
    chk(nmeas, 4);
    chk(ntrig, 2);
    // External source scan: held until a trigger comes
    run(32'h00B, 4, 2);
    repeat (20) @(posedge core_clk);
    chk(nmeas, 0);
    u_far.fire;
    repeat (60) @(posedge core_clk);
    chk(nmeas, 2);
    chk(ntrig, 1);
    // Manual trigger does the second scan
    apb(1'b1, `STS_CTRL_ADDR, 32'h10B);
    wait_end;
    chk(nmeas, 4);
    chk(u_far.heard, 10);
    // Infinite count runs on until stopped
    run(32'h001, 0, 2);
    repeat (150) @(posedge core_clk);
    apb(1'b1, `STS_CTRL_ADDR, 32'h080);
    wait_end;
    chk(nmeas > 4, 1);
    end_sim;
  end
endmodule
